// ==== hw/eeprom_cmd_pkg.sv ====
// constants and types of the serial eeprom command controller
package eeprom_cmd_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CMD      = 8'hB0;
    localparam logic [7:0] OFS_DATA     = 8'hB4;
    localparam logic [7:0] OFS_IRQ_STS  = 8'hB8;
    localparam logic [7:0] OFS_IRQ_MASK = 8'hBC;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int BIT_BUSY    = 31;
    localparam int CMD_HI      = 30;
    localparam int CMD_LO      = 28;
    localparam int BIT_TIMEOUT = 9;
    localparam int BIT_LOADED  = 8;
    localparam int IRQ_DONE    = 0;
    localparam int IRQ_TIMEOUT = 1;
    localparam int IRQ_LOADED  = 2;
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [2:0] IRQ_RST  = 3'h0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned TIMEOUT_MS    = 30;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned TIMEOUT_CYC   = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned SCLK_HALF_CYC = 4;

    // ------------------------------------------------------------
    // memory framing: {start bit, 2-bit opcode}, address byte, lengths
    // ------------------------------------------------------------
    localparam logic [7:0] SIGNATURE  = 8'hA5;
    localparam logic [2:0] LAST_IDX   = 3'h6;
    localparam logic [2:0] PFX_READ   = 3'h6;
    localparam logic [2:0] PFX_WRITE  = 3'h5;
    localparam logic [2:0] PFX_ERASE  = 3'h7;
    localparam logic [2:0] PFX_MISC   = 3'h4;
    localparam logic [7:0] ADR_UNLOCK = 8'hC0;
    localparam logic [7:0] ADR_LOCK   = 8'h00;
    localparam logic [7:0] ADR_WRALL  = 8'h40;
    localparam logic [7:0] ADR_ERALL  = 8'h80;
    localparam logic [4:0] SHORT_BITS = 5'h0B;
    localparam logic [4:0] LONG_BITS  = 5'h13;
    localparam logic [4:0] DATA_BITS  = 5'h08;

    typedef enum logic [2:0] {
        CMD_READ          = 3'h0,
        CMD_PROGRAM_LOCK  = 3'h1,
        CMD_PROGRAM_UNLOCK = 3'h2,
        CMD_WRITE         = 3'h3,
        CMD_PROGRAM_ALL   = 3'h4,
        CMD_ERASE         = 3'h5,
        CMD_BULK_ERASE    = 3'h6,
        CMD_RELOAD        = 3'h7
    } cmd_type;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_SEND = 5'h02,
        ST_RECV = 5'h04,
        ST_GAP  = 5'h08,
        ST_WAIT = 5'h10
    } state_type;

endpackage

// ==== hw/serial_eeprom_command_controller.sv ====
// serial eeprom command controller with apb registers
//
// Contract
// - busy held from command until done, and boot
// - command codes 0..7 decoded as listed
// - write-all programs data byte everywhere
// - reload checks first byte against signature
// - no memory response in time aborts to idle
// - time-out sets sticky write-one-clear flag
// - data line high means ready, no time-out
// - only programming commands ever wait or time out
// - successful address load sets write-one-clear flag
// - eight-bit address field selects location
// - data byte in low bits, upper zero
`timescale 1ns/10ps
`default_nettype none

module serial_eeprom_command_controller #(
    parameter int unsigned TIMEOUT_CYC = eeprom_cmd_pkg::TIMEOUT_CYC,
    parameter int unsigned SCLK_HALF   = eeprom_cmd_pkg::SCLK_HALF_CYC
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // interrupt
    output logic             irq,
    // serial memory pins
    output logic             ee_cs,
    output logic             ee_sclk,
    input  wire logic        serial_memory_data_line_in,
    output logic             serial_memory_data_line_out,
    output logic             serial_memory_data_line_oe_n,
    // loaded station address
    output logic      [47:0] station_address
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_r;
    logic rst_n;

    // asserts at once, releases after two edges
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    eeprom_cmd_pkg::state_type state_r;
    eeprom_cmd_pkg::cmd_type   cmd_r;
    logic        busy_r, reload_r, unlock_r, rd_op_r, wt_op_r;
    logic [2:0]  idx_r;
    logic [18:0] shreg_r;
    logic [4:0]  nbits_r;
    logic [15:0] div_r;
    logic [31:0] to_cnt_r;
    logic [7:0]  rdata_r, addr_r, data_r;
    logic        to_ev_r, ld_ev_r, rd_ev_r, done_ev_r;
    logic        to_flag_r, ld_flag_r;
    logic [2:0]  sts_r, mask_r;
    logic        tick, wr_acc, cmd_go;
    logic [2:0]  pfx;
    logic [7:0]  fadr;
    logic [4:0]  flen;
    logic        lk, wt;
    logic        din;

    assign din    = serial_memory_data_line_in;
    assign tick   = div_r == 16'(SCLK_HALF - 1);
    assign wr_acc = psel && penable && pwrite && pready;
    // software may only start when idle; a busy-time start is dropped
    assign cmd_go = wr_acc && paddr == eeprom_cmd_pkg::OFS_CMD && pwdata[eeprom_cmd_pkg::BIT_BUSY] && !busy_r;

    // ------------------------------------------------------------
    // command decode into a serial frame
    // ------------------------------------------------------------
    // reload reads by index, read by address field
    always_comb begin
        pfx  = eeprom_cmd_pkg::PFX_MISC;
        fadr = addr_r;
        flen = eeprom_cmd_pkg::SHORT_BITS;
        lk   = 1'b0;
        wt   = 1'b0;
        unique case (cmd_r)
            eeprom_cmd_pkg::CMD_READ, eeprom_cmd_pkg::CMD_RELOAD: begin
                pfx  = eeprom_cmd_pkg::PFX_READ;
                fadr = reload_r ? {5'h00, idx_r} : addr_r;
            end
            eeprom_cmd_pkg::CMD_PROGRAM_LOCK:   fadr = eeprom_cmd_pkg::ADR_LOCK;
            eeprom_cmd_pkg::CMD_PROGRAM_UNLOCK: fadr = eeprom_cmd_pkg::ADR_UNLOCK;
            eeprom_cmd_pkg::CMD_WRITE: begin
                pfx  = eeprom_cmd_pkg::PFX_WRITE;
                flen = eeprom_cmd_pkg::LONG_BITS;
                lk   = 1'b1;
                wt   = 1'b1;
            end
            eeprom_cmd_pkg::CMD_PROGRAM_ALL: begin
                fadr = eeprom_cmd_pkg::ADR_WRALL;
                flen = eeprom_cmd_pkg::LONG_BITS;
                lk   = 1'b1;
                wt   = 1'b1;
            end
            eeprom_cmd_pkg::CMD_ERASE: begin
                pfx  = eeprom_cmd_pkg::PFX_ERASE;
                lk   = 1'b1;
                wt   = 1'b1;
            end
            eeprom_cmd_pkg::CMD_BULK_ERASE: begin
                fadr = eeprom_cmd_pkg::ADR_ERALL;
                lk   = 1'b1;
                wt   = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // sequencer: framing, shifting, ready wait, reload walk
    // ------------------------------------------------------------
    // busy comes up at reset so the boot reload runs first
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r  <= eeprom_cmd_pkg::ST_IDLE;
            busy_r   <= 1'b1;
            reload_r <= 1'b1;
            unlock_r <= 1'b0;
            rd_op_r  <= 1'b0;
            wt_op_r  <= 1'b0;
            idx_r    <= 3'h0;
            shreg_r  <= 19'h00000;
            nbits_r  <= 5'h00;
            div_r    <= 16'h0000;
            to_cnt_r <= 32'h00000000;
            rdata_r  <= 8'h00;
            ee_cs    <= 1'b0;
            ee_sclk  <= 1'b0;
            serial_memory_data_line_oe_n <= 1'b1;
            station_address <= 48'h000000000000;
            to_ev_r   <= 1'b0;
            ld_ev_r   <= 1'b0;
            rd_ev_r   <= 1'b0;
            done_ev_r <= 1'b0;
        end else begin
            to_ev_r   <= 1'b0;
            ld_ev_r   <= 1'b0;
            rd_ev_r   <= 1'b0;
            done_ev_r <= 1'b0;
            div_r     <= tick ? 16'h0000 : div_r + 16'h0001;
            unique case (state_r)
                eeprom_cmd_pkg::ST_IDLE: begin
                    ee_cs   <= 1'b0;
                    ee_sclk <= 1'b0;
                    div_r   <= 16'h0000;
                    if (cmd_go) begin
                        busy_r   <= 1'b1;
                        reload_r <= pwdata[eeprom_cmd_pkg::CMD_HI:eeprom_cmd_pkg::CMD_LO] == 3'h7;
                        idx_r    <= 3'h0;
                    end else if (busy_r) begin
                        if (lk && !unlock_r) begin
                            busy_r    <= 1'b0;
                            done_ev_r <= 1'b1;
                        end else begin
                            shreg_r <= {pfx, fadr, data_r};
                            nbits_r <= flen;
                            rd_op_r <= pfx == eeprom_cmd_pkg::PFX_READ;
                            wt_op_r <= wt;
                            ee_cs   <= 1'b1;
                            serial_memory_data_line_oe_n <= 1'b0;
                            state_r <= eeprom_cmd_pkg::ST_SEND;
                            if (cmd_r == eeprom_cmd_pkg::CMD_PROGRAM_UNLOCK) unlock_r <= 1'b1;
                            if (cmd_r == eeprom_cmd_pkg::CMD_PROGRAM_LOCK) unlock_r <= 1'b0;
                        end
                    end
                end
                eeprom_cmd_pkg::ST_SEND: if (tick) begin
                    ee_sclk <= !ee_sclk;
                    // bits change on the falling edge, memory samples on rising
                    if (ee_sclk) begin
                        if (nbits_r == 5'h01) begin
                            serial_memory_data_line_oe_n <= 1'b1;
                            if (rd_op_r) begin
                                nbits_r <= eeprom_cmd_pkg::DATA_BITS;
                                state_r <= eeprom_cmd_pkg::ST_RECV;
                            end else if (wt_op_r) begin
                                ee_cs   <= 1'b0;
                                state_r <= eeprom_cmd_pkg::ST_GAP;
                            end else begin
                                busy_r    <= 1'b0;
                                done_ev_r <= 1'b1;
                                state_r   <= eeprom_cmd_pkg::ST_IDLE;
                            end
                        end else begin
                            shreg_r <= {shreg_r[17:0], 1'b0};
                            nbits_r <= nbits_r - 5'h01;
                        end
                    end
                end
                eeprom_cmd_pkg::ST_RECV: if (tick) begin
                    ee_sclk <= !ee_sclk;
                    if (!ee_sclk) begin
                        rdata_r <= {rdata_r[6:0], din};
                        nbits_r <= nbits_r - 5'h01;
                    end else if (nbits_r == 5'h00) begin
                        state_r <= eeprom_cmd_pkg::ST_IDLE;
                        // drop select so chained reload reads stay separate frames
                        ee_cs   <= 1'b0;
                        if (!reload_r) begin
                            rd_ev_r   <= 1'b1;
                            busy_r    <= 1'b0;
                            done_ev_r <= 1'b1;
                        end else if (idx_r == 3'h0 && rdata_r != eeprom_cmd_pkg::SIGNATURE) begin
                            reload_r  <= 1'b0;
                            busy_r    <= 1'b0;
                            done_ev_r <= 1'b1;
                        end else begin
                            if (idx_r != 3'h0) station_address[8*(idx_r-3'h1) +: 8] <= rdata_r;
                            idx_r <= idx_r + 3'h1;
                            if (idx_r == eeprom_cmd_pkg::LAST_IDX) begin
                                reload_r  <= 1'b0;
                                ld_ev_r   <= 1'b1;
                                busy_r    <= 1'b0;
                                done_ev_r <= 1'b1;
                            end
                        end
                    end
                end
                // chip select low for one half bit before polling ready
                eeprom_cmd_pkg::ST_GAP: if (tick) begin
                    ee_cs    <= 1'b1;
                    to_cnt_r <= 32'h00000000;
                    state_r  <= eeprom_cmd_pkg::ST_WAIT;
                end
                eeprom_cmd_pkg::ST_WAIT: begin
                    to_cnt_r <= to_cnt_r + 32'h00000001;
                    if (din || to_cnt_r == TIMEOUT_CYC - 1) begin
                        to_ev_r   <= !din;
                        busy_r    <= 1'b0;
                        done_ev_r <= 1'b1;
                        state_r   <= eeprom_cmd_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign serial_memory_data_line_out = shreg_r[18];

    // ------------------------------------------------------------
    // command, address and data registers
    // ------------------------------------------------------------
    // frozen while busy so a running frame never sees a change
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_r  <= eeprom_cmd_pkg::CMD_READ;
            addr_r <= eeprom_cmd_pkg::ADDR_RST;
            data_r <= eeprom_cmd_pkg::DATA_RST;
        end else begin
            if (wr_acc && !busy_r && paddr == eeprom_cmd_pkg::OFS_CMD) begin
                cmd_r  <= eeprom_cmd_pkg::cmd_type'(pwdata[eeprom_cmd_pkg::CMD_HI:eeprom_cmd_pkg::CMD_LO]);
                addr_r <= pwdata[7:0];
            end
            if (rd_ev_r) data_r <= rdata_r;
            else if (wr_acc && !busy_r && paddr == eeprom_cmd_pkg::OFS_DATA) data_r <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // sticky flags and interrupt
    // ------------------------------------------------------------
    // a new event wins over a same-cycle write-one clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            to_flag_r <= 1'b0;
            ld_flag_r <= 1'b0;
            sts_r     <= eeprom_cmd_pkg::IRQ_RST;
            mask_r    <= eeprom_cmd_pkg::IRQ_RST;
            irq       <= 1'b0;
        end else begin
            to_flag_r <= to_ev_r | (to_flag_r & !(wr_acc && paddr == eeprom_cmd_pkg::OFS_CMD
                         && pwdata[eeprom_cmd_pkg::BIT_TIMEOUT]));
            ld_flag_r <= ld_ev_r | (ld_flag_r & !(wr_acc && paddr == eeprom_cmd_pkg::OFS_CMD
                         && pwdata[eeprom_cmd_pkg::BIT_LOADED]));
            sts_r <= {ld_ev_r, to_ev_r, done_ev_r}
                     | (sts_r & ~((wr_acc && paddr == eeprom_cmd_pkg::OFS_IRQ_STS) ? pwdata[2:0] : 3'h0));
            if (wr_acc && paddr == eeprom_cmd_pkg::OFS_IRQ_MASK) mask_r <= pwdata[2:0];
            irq <= |(sts_r & mask_r);
        end
    end

    // ------------------------------------------------------------
    // apb answer: no wait state, data captured in setup
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            if (psel && !penable) begin
                unique case (paddr)
                    eeprom_cmd_pkg::OFS_CMD:  prdata <= {busy_r, cmd_r, 18'h00000, to_flag_r, ld_flag_r, addr_r};
                    eeprom_cmd_pkg::OFS_DATA: prdata <= {24'h000000, data_r};
                    eeprom_cmd_pkg::OFS_IRQ_STS:  prdata <= {29'h00000000, sts_r};
                    eeprom_cmd_pkg::OFS_IRQ_MASK: prdata <= {29'h00000000, mask_r};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_launch(eeprom_cmd_pkg::cmd_type c);
        state_r == eeprom_cmd_pkg::ST_IDLE && busy_r && !cmd_go && !reload_r && cmd_r == c;
    endsequence
    sequence s_wait_expire;
        state_r == eeprom_cmd_pkg::ST_WAIT && !din && to_cnt_r == TIMEOUT_CYC - 1;
    endsequence

    a_busy_held: assert property (state_r != eeprom_cmd_pkg::ST_IDLE |-> busy_r) else $error("busy low mid op");
    a_boot_busy: assert property ($rose(rst_n) |-> busy_r && reload_r) else $error("no boot reload");
    a_write_frame: assert property (s_launch(eeprom_cmd_pkg::CMD_WRITE) and unlock_r |=>
        shreg_r == {eeprom_cmd_pkg::PFX_WRITE, addr_r, data_r} && nbits_r == 5'h13) else $error("bad write frame");
    a_program_every_location_frame: assert property (s_launch(eeprom_cmd_pkg::CMD_PROGRAM_ALL) and unlock_r |=>
        shreg_r == {3'h4, 8'h40, data_r} && state_r == eeprom_cmd_pkg::ST_SEND) else $error("bad write-all");
    a_locked_skip: assert property (s_launch(eeprom_cmd_pkg::CMD_WRITE) and !unlock_r |=>
        !busy_r && !ee_cs) else $error("locked write sent");
    a_bulk_erase: assert property (s_launch(eeprom_cmd_pkg::CMD_BULK_ERASE) and unlock_r |=>
        shreg_r[18:8] == 11'h480) else $error("bad bulk erase");
    a_sig_fail: assert property (state_r == eeprom_cmd_pkg::ST_RECV && tick && ee_sclk && nbits_r == 5'h00
        && reload_r && idx_r == 3'h0 && rdata_r != 8'hA5 |=> !busy_r && !ld_ev_r ##1 !ld_ev_r)
        else $error("bad signature accepted");
    a_timeout_abort: assert property (s_wait_expire |=> state_r == eeprom_cmd_pkg::ST_IDLE && !busy_r
        ##1 to_flag_r && sts_r[1]) else $error("time-out not taken");
    a_ready_release: assert property (state_r == eeprom_cmd_pkg::ST_WAIT && din |=> !busy_r && !to_ev_r)
        else $error("ready ignored");
    a_read_no_wait: assert property (state_r == eeprom_cmd_pkg::ST_WAIT |-> cmd_r inside {
        eeprom_cmd_pkg::CMD_WRITE, eeprom_cmd_pkg::CMD_PROGRAM_ALL,
        eeprom_cmd_pkg::CMD_ERASE, eeprom_cmd_pkg::CMD_BULK_ERASE})
        else $error("non-programming command waited");
    a_loaded_set: assert property (ld_ev_r |=> ld_flag_r) else $error("loaded flag lost");
    a_data_upper: assert property (psel && !penable && paddr == 8'hB4 |=> prdata[31:8] == 24'h000000)
        else $error("data upper bits set");
    a_cmd_reserved: assert property (psel && !penable && paddr == 8'hB0 |=> prdata[27:10] == 18'h00000)
        else $error("reserved bits set");

endmodule

`default_nettype wire

// ==== verif/eeprom_model.sv ====
// behavioural serial memory that sits on the far side of the controller
`timescale 1ns/10ps
`default_nettype none

module eeprom_model (
    // serial pins
    input  wire logic ee_cs,
    input  wire logic ee_sclk,
    input  wire logic d_out,
    input  wire logic oe_n,
    output logic      d_in,
    // fault and pacing controls
    input  wire logic fitted,
    input  wire logic pull,
    input  wire logic dead,
    input  wire logic slow
);
    logic [7:0]  mem [256];
    logic [18:0] sr;
    logic [10:0] h;
    logic [7:0]  rsr;
    logic [4:0]  cnt = 5'h00;
    logic        en = 1'b0;
    logic        rd = 1'b0;
    logic        pend = 1'b0;
    logic        rdy = 1'b0;
    logic        dout = 1'b0;
    logic        pg;

    // preload: signature then a recognisable pattern
    initial begin
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i * 17);
        mem[0] = 8'hA5;
    end

    // released line toggles so a stale level never reads as ready
    assign d_in = !oe_n ? d_out : !fitted ? pull : pend ? rdy : dout;

    // new frame restarts the bit count
    always @(posedge ee_cs) begin
        cnt <= 5'h00;
        rd <= 1'b0;
    end

    // bits sampled on rising clock; read byte latched after the address
    always @(posedge ee_sclk) begin
        if (ee_cs) begin
            sr <= {sr[17:0], d_out};
            cnt <= cnt + 5'h01;
            if (cnt == 5'h0A) begin
                rsr <= mem[{sr[6:0], d_out}];
                rd <= (sr[8:7] == 2'b10);
            end
        end
    end

    // read data changes on falling clock, msb first
    always @(negedge ee_sclk) begin
        dout <= rd ? rsr[7] : ~dout;
        rsr <= rsr << 1;
    end

    // frame end: lock state, programming, then busy until ready
    always @(negedge ee_cs) begin
        pend <= 1'b0;
        if (cnt == 5'h13 || cnt == 5'h0B) begin
            h = (cnt == 5'h13) ? sr[18:8] : sr[10:0];
            if (h[9:6] == 4'b0011 || h[9:6] == 4'b0000)
                en = h[7];
            pg = h[8] | (h[9:8] == 2'b00 && (h[7] ^ h[6]));
            for (int i = 0; i < 256; i++)
                if (en && pg && (h[9:8] == 2'b00 || i == h[7:0]))
                    mem[i] = ((h[9:8] == 2'b00) ? h[6] : ~h[9]) ? sr[7:0] : 8'hFF;
            pend <= pg;
            rdy = 1'b0;
            if (pg && !dead)
                rdy <= #(slow ? 3000 : 300) 1'b1;
        end
    end
endmodule

`default_nettype wire

// ==== verif/test_serial_eeprom_command_controller.sv ====
// self-checking bench for the serial eeprom command controller
`timescale 1ns/10ps
`default_nettype none

module test_serial_eeprom_command_controller;
    localparam logic [7:0] CMD = eeprom_cmd_pkg::OFS_CMD;
    localparam logic [7:0] DAT = eeprom_cmd_pkg::OFS_DATA;
    localparam logic [7:0] STS = eeprom_cmd_pkg::OFS_IRQ_STS;
    localparam logic [7:0] MSK = eeprom_cmd_pkg::OFS_IRQ_MASK;
    logic        ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00, a, d;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, irq, ee_cs, ee_sclk, dout, oe_n, din;
    logic        fitted = 1, pull = 1, dead = 0, slow = 0;
    logic [47:0] sta;
    logic [64:0] q[$], nt;
    int          err_count = 0, check_count = 0, cyc = 0;

    always #50 ref_clk = ~ref_clk;

    serial_eeprom_command_controller #(.TIMEOUT_CYC(200), .SCLK_HALF(1)) i_serial_eeprom_command_controller (
        .ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
        .ee_cs, .ee_sclk, .serial_memory_data_line_in(din), .serial_memory_data_line_out(dout),
        .serial_memory_data_line_oe_n(oe_n), .station_address(sta));
    eeprom_model i_eeprom_model (.ee_cs, .ee_sclk, .d_out(dout), .oe_n, .d_in(din),
        .fitted, .pull, .dead, .slow);

    task automatic chk(string n, logic [47:0] e, logic [47:0] s);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // one apb transfer; held until pready is sampled high
    task automatic xfer(logic w, logic [7:0] ad, logic [31:0] wd);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // note the expected word, then read it
    task automatic rd(logic [7:0] ad, logic [31:0] e, logic [31:0] m = '1, logic er = 0);
        q.push_back({er, m, e & m});
        xfer(1'b0, ad, 32'h0);
    endtask
    // poll with a don't-care note until busy drops, bounded
    task automatic idle;
        r = 32'hFFFF_FFFF;
        for (int i = 0; i < 400 && r[31] !== 1'b0; i++)
            rd(CMD, 0, 0);
        chk("busy", 48'h0, 48'(r[31]));
    endtask
    task automatic cmd(logic [2:0] c, logic [7:0] ad, logic b);
        xfer(1'b1, CMD, {1'b1, c, 20'h0, ad});
        if (b) rd(CMD, 32'h8000_0000, 32'h8000_0000);
        idle();
    endtask

    // monitor: each completed read is matched with the oldest note
    always @(posedge ref_clk) begin
        if (psel && penable && pready && !pwrite) begin
            nt = q.pop_front();
            chk("prdata", 48'(nt[31:0]), 48'(prdata & nt[63:32]));
            chk("pslverr", 48'(nt[64]), 48'(pslverr));
        end
    end
    // hang guard well above the expected run length
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            print_verdict();
        end
    end

    initial begin
        void'($urandom(32'h221a6081));
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        // internal reset copy lags two edges; a setup seen in reset is lost
        repeat (2) @(posedge ref_clk);
        idle();
        rd(CMD, 32'h0000_0100, 32'h8000_03FF);
        chk("station", 48'h6655_4433_2211, sta);
        rd(DAT, 0);
        xfer(1, DAT, 32'hFFFF_FF3C);
        rd(DAT, 32'h3C);
        xfer(1, CMD, 32'h0FFF_FD00);
        rd(CMD, 0, 32'h0FFF_FF00);
        rd(8'hC0, 0, '1, 1'b1);
        $display("test registers done");
        a = 8'($urandom_range(8, 255));
        d = 8'($urandom);
        xfer(1, DAT, {24'h0, d});
        cmd(2, 0, 1);
        cmd(3, a, 1);
        xfer(1, DAT, 0);
        cmd(0, a, 1);
        rd(DAT, {24'h0, d});
        cmd(5, a, 1);
        cmd(0, a, 1);
        rd(DAT, 32'hFF);
        xfer(1, DAT, {24'h0, ~d});
        cmd(4, 0, 1);
        cmd(0, a ^ 8'h55, 1);
        rd(DAT, {24'h0, ~d});
        slow <= 1'b1;
        cmd(6, 0, 1);
        cmd(0, a, 1);
        rd(DAT, 32'hFF);
        cmd(1, 0, 1);
        cmd(3, a, 0);
        cmd(0, a, 1);
        rd(DAT, 32'hFF);
        $display("test commands done");
        cmd(7, 0, 1);
        rd(CMD, 0, 32'h300);
        chk("station", 48'h6655_4433_2211, sta);
        cmd(2, 0, 1);
        xfer(1, DAT, 32'hA5);
        cmd(3, 0, 1);
        xfer(1, DAT, 32'h5A);
        cmd(3, 1, 1);
        cmd(7, 0, 1);
        rd(CMD, 32'h100, 32'h300);
        chk("station", 48'hFFFF_FFFF_FF5A, sta);
        $display("test reload done");
        xfer(1, CMD, 32'h300);
        xfer(1, STS, 32'h7);
        xfer(1, MSK, 32'h0);
        dead <= 1'b1;
        cmd(3, a, 1);
        rd(CMD, 32'h200, 32'h8000_0200);
        rd(STS, 32'h2, 32'h2);
        chk("irq", 48'h0, 48'(irq));
        xfer(1, MSK, 32'h2);
        rd(STS, 32'h2, 32'h2);
        chk("irq", 48'h1, 48'(irq));
        xfer(1, CMD, 32'h200);
        xfer(1, STS, 32'h7);
        rd(CMD, 0, 32'h200);
        chk("irq", 48'h0, 48'(irq));
        $display("test timeout done");
        dead <= 1'b0;
        fitted <= 1'b0;
        cmd(3, a, 1);
        rd(CMD, 0, 32'h200);
        pull <= 1'b0;
        cmd(0, a, 1);
        rd(CMD, 0, 32'h200);
        cmd(6, 0, 1);
        rd(CMD, 32'h200, 32'h200);
        $display("test absent memory done");
        print_verdict();
    end
endmodule

`default_nettype wire
